// file: rbsm_map.svh
// Register offsets, field positions, reset values and coefficient layout.
`ifndef RBSM_MAP_SVH
`define RBSM_MAP_SVH
`define RBSM_CFG_OFS        12'h000
`define RBSM_STAT_OFS       12'h004
`define RBSM_IN01_OFS       12'h008
`define RBSM_IN23_OFS       12'h00C
`define RBSM_PAGE_OFS       12'h010
`define RBSM_CBYTE_OFS      12'h014
`define RBSM_MIX_OFS        12'h100
`define RBSM_COEF_OFS       12'h400
`define RBSM_CFG_SUM_LSB    2
`define RBSM_CFG_BQ_LSB     5
`define RBSM_SUM_RST        2'h0
`define RBSM_BQ_RST         2'h2
`define RBSM_COEF_BASE      8'h08
`define RBSM_COEF_BYTES     8'h14
`define RBSM_N0_RST         32'h7FFFFFFF
`define RBSM_SECT_PER_PAGE  6
`endif

// file: rbsm_pkg.sv
// Types shared by the record biquad, summer and mixer block.
package rbsm_pkg;
  typedef enum logic [1:0] {
    RBSM_SUM_OFF = 2'h0,
    RBSM_SUM_AVG = 2'h1
  } rbsm_sum_t;
  typedef enum logic [3:0] {
    RBSM_IDLE = 4'h1,
    RBSM_LOAD = 4'h2,
    RBSM_SECT = 4'h4,
    RBSM_DONE = 4'h8
  } rbsm_state_t;
endpackage : rbsm_pkg

// file: rbsm_biquad.sv
// One shared biquad arithmetic stage: a single section step.
`timescale 1ns/1ps
module rbsm_biquad
  import rbsm_pkg::*;
(
  // Sample and history
  input  wire logic signed [31:0] x_i,
  input  wire logic signed [31:0] x1_i,
  input  wire logic signed [31:0] x2_i,
  input  wire logic signed [31:0] y1_i,
  input  wire logic signed [31:0] y2_i,
  // Coefficients
  input  wire logic signed [31:0] n0_i,
  input  wire logic signed [31:0] n1_i,
  input  wire logic signed [31:0] n2_i,
  input  wire logic signed [31:0] d1_i,
  input  wire logic signed [31:0] d2_i,
  // Result
  output logic signed [31:0]      y_o
);
  logic signed [95:0] acc;
  // Denominator is normalised by 2^31, so the sum is shifted by 31.
  always_comb
  begin
    acc = 96'(n0_i * x_i) + 96'(2 * 96'(n1_i * x1_i)) + 96'(n2_i * x2_i)
        + 96'(2 * 96'(d1_i * y1_i)) + 96'(d2_i * y2_i);
    y_o = acc[62:31];
  end
endmodule : rbsm_biquad

// file: rbsm_top.sv
// Record-path biquad sections, channel summer and two mixers.
// Overview of operation
// - Twelve independently programmable biquad sections provided.
// - Each section: two poles, two zeros, five coefficients.
// - One per channel: sections 1-4 feed channels.
// - Reset two per channel: 1-4 then 5-8.
// - Three per channel: 1-4, 5-8, 9-12 used.
// - Twenty bytes per section, two pages, offset eight.
// - Summing mode averages channels 1 and 2 with equal weight.
// - Channel sum select resets to disabled.
// - Code 01: outputs 1,2 carry inputs' average.
// - Mixer acts only when sum select is zero.
// - Mixer output is weighted sum of inputs.
// - Mixer one feeds channel 1, mixer two channel 2.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "rbsm_map.svh"
module rbsm_top
  import rbsm_pkg::*;
#(
  parameter int NSECT = 12,
  parameter int NCH   = 4
)
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Sample stream from decimation
  input  wire logic        in_valid_i,
  input  wire logic [31:0] in_ch0_i,
  input  wire logic [31:0] in_ch1_i,
  input  wire logic [31:0] in_ch2_i,
  input  wire logic [31:0] in_ch3_i,
  // Sample stream to serial output
  output logic             out_valid_o,
  output logic [31:0]      out_ch0_o,
  output logic [31:0]      out_ch1_o,
  output logic [31:0]      out_ch2_o,
  output logic [31:0]      out_ch3_o
);
  // Coefficient byte memory: 2 pages of 128 bytes.
  logic [7:0]  coef_mem [0:255];
  logic [1:0]  bq_cfg_ff, nxt_bq_cfg;
  logic [1:0]  sum_sel_ff, nxt_sum_sel;
  logic [31:0] mix_ff [0:7];
  logic [31:0] nxt_mix [0:7];
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic        out_valid_ff, nxt_out_valid;
  logic        wr_coef;
  logic [7:0]  wr_coef_idx;

  // Byte address of coefficient k (0..4) of section s (0..11).
  function automatic logic [7:0] coef_addr(input int s, input int k);
    int base;
    base = (s / `RBSM_SECT_PER_PAGE) * 128 + int'(`RBSM_COEF_BASE)
         + (s % `RBSM_SECT_PER_PAGE) * int'(`RBSM_COEF_BYTES)
         + k * 4;
    return 8'(base);
  endfunction : coef_addr

  function automatic logic [31:0] coef_word(input int s, input int k);
    logic [7:0] a;
    a = coef_addr(s, k);
    // Most significant byte sits at the lowest offset.
    return {coef_mem[a], coef_mem[8'(a + 8'h01)],
            coef_mem[8'(a + 8'h02)], coef_mem[8'(a + 8'h03)]};
  endfunction : coef_word

  // APB access completes after one wait state; unmapped reads give zero.
  logic acc_en;
  assign acc_en = psel_i && penable_i && !pready_ff;

  always_comb
  begin
    nxt_bq_cfg  = bq_cfg_ff;
    nxt_sum_sel = sum_sel_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    wr_coef     = 1'b0;
    wr_coef_idx = paddr_i[9:2];
    for (int i = 0; i < 8; i++)
      nxt_mix[i] = mix_ff[i];
    if (acc_en)
    begin
      nxt_pready = 1'b1;
      nxt_prdata = 32'h00000000;
      if (paddr_i == `RBSM_CFG_OFS)
      begin
        if (pwrite_i)
        begin
          nxt_bq_cfg  = pwdata_i[`RBSM_CFG_BQ_LSB +: 2];
          // Reserved codes are the host's to avoid; they bypass mixing.
          nxt_sum_sel = pwdata_i[`RBSM_CFG_SUM_LSB +: 2];
        end
        else
        begin
          nxt_prdata[`RBSM_CFG_BQ_LSB +: 2]  = bq_cfg_ff;
          nxt_prdata[`RBSM_CFG_SUM_LSB +: 2] = sum_sel_ff;
        end
      end
      else if (paddr_i == `RBSM_STAT_OFS)
      begin
        nxt_prdata = {28'h0000000, out_valid_ff, sum_sel_ff != 2'h0,
                      bq_cfg_ff};
      end
      else if (paddr_i[11:5] == 7'(`RBSM_MIX_OFS >> 5))
      begin
        if (pwrite_i)
          nxt_mix[paddr_i[4:2]] = pwdata_i;
        else
          nxt_prdata = mix_ff[paddr_i[4:2]];
      end
      else if (paddr_i[11:10] == 2'h1)
      begin
        // Each coefficient byte occupies one APB word.
        if (pwrite_i)
          wr_coef = 1'b1;
        else
          nxt_prdata = {24'h000000, coef_mem[paddr_i[9:2]]};
      end
      else
        nxt_pslverr = 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bq_cfg_ff  <= `RBSM_BQ_RST;
      sum_sel_ff <= `RBSM_SUM_RST;
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      for (int i = 0; i < 8; i++)
        mix_ff[i] <= 32'h00000000;
    end
    else
    begin
      bq_cfg_ff  <= nxt_bq_cfg;
      sum_sel_ff <= nxt_sum_sel;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      for (int i = 0; i < 8; i++)
        mix_ff[i] <= nxt_mix[i];
    end
  end

  // Coefficient memory has no reset; it is cleared to pass-through only
  // by software, which keeps the array in plain storage.
  always_ff @(posedge clock_i)
  begin
    if (wr_coef)
      coef_mem[wr_coef_idx] <= pwdata_i[7:0];
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;

  // Sequencer: one section per cycle through a shared arithmetic stage.
  rbsm_state_t      st_ff, nxt_st;
  logic [3:0]       sect_ff, nxt_sect;
  logic [31:0]      x1_ff [0:11];
  logic [31:0]      x2_ff [0:11];
  logic [31:0]      y1_ff [0:11];
  logic [31:0]      y2_ff [0:11];
  logic [31:0]      nxt_x1 [0:11];
  logic [31:0]      nxt_x2 [0:11];
  logic [31:0]      nxt_y1 [0:11];
  logic [31:0]      nxt_y2 [0:11];
  logic [31:0]      chv_ff [0:3];
  logic [31:0]      nxt_chv [0:3];
  logic [31:0]      in_ff [0:3];
  logic [31:0]      nxt_in [0:3];
  logic [31:0]      out_ff [0:3];
  logic [31:0]      nxt_out [0:3];
  logic signed [31:0] bq_y;
  logic [3:0]       nsect_used;
  logic [1:0]       cur_ch;
  logic [3:0]       sidx;

  // Allocation: section s serves channel s mod 4; count by setting.
  always_comb
  begin
    unique case (bq_cfg_ff)
      2'h1:    nsect_used = 4'h4;
      2'h2:    nsect_used = 4'h8;
      2'h3:    nsect_used = 4'hC;
      default: nsect_used = 4'h0;
    endcase
  end

  assign sidx   = sect_ff;
  assign cur_ch = sect_ff[1:0];

  rbsm_biquad u_bq (
    .x_i  (chv_ff[cur_ch]),
    .x1_i (x1_ff[sidx]),
    .x2_i (x2_ff[sidx]),
    .y1_i (y1_ff[sidx]),
    .y2_i (y2_ff[sidx]),
    .n0_i (coef_word(int'(sidx), 0)),
    .n1_i (coef_word(int'(sidx), 1)),
    .n2_i (coef_word(int'(sidx), 2)),
    .d1_i (coef_word(int'(sidx), 3)),
    .d2_i (coef_word(int'(sidx), 4)),
    .y_o  (bq_y)
  );

  logic signed [33:0] avg_sum;
  logic signed [65:0] mix_acc [0:1];

  always_comb
  begin
    nxt_st        = st_ff;
    nxt_sect      = sect_ff;
    nxt_out_valid = 1'b0;
    avg_sum       = 34'(signed'(chv_ff[0])) + 34'(signed'(chv_ff[1]));
    for (int c = 0; c < 4; c++)
    begin
      nxt_chv[c] = chv_ff[c];
      nxt_in[c]  = in_ff[c];
      nxt_out[c] = out_ff[c];
    end
    for (int m = 0; m < 2; m++)
    begin
      mix_acc[m] = 66'h0;
      for (int c = 0; c < 4; c++)
        mix_acc[m] = mix_acc[m] + 66'(signed'(mix_ff[m*4+c])
                   * signed'(chv_ff[c]));
    end
    for (int s = 0; s < 12; s++)
    begin
      nxt_x1[s] = x1_ff[s];
      nxt_x2[s] = x2_ff[s];
      nxt_y1[s] = y1_ff[s];
      nxt_y2[s] = y2_ff[s];
    end
    unique case (st_ff)
      RBSM_IDLE:
        if (in_valid_i)
        begin
          nxt_in[0] = in_ch0_i;
          nxt_in[1] = in_ch1_i;
          nxt_in[2] = in_ch2_i;
          nxt_in[3] = in_ch3_i;
          nxt_st    = RBSM_LOAD;
        end
      RBSM_LOAD:
      begin
        for (int c = 0; c < 4; c++)
          nxt_chv[c] = in_ff[c];
        nxt_sect = 4'h0;
        nxt_st   = (nsect_used == 4'h0) ? RBSM_DONE : RBSM_SECT;
      end
      RBSM_SECT:
      begin
        // Ascending order puts lower sections first in each cascade.
        nxt_chv[cur_ch] = bq_y;
        nxt_x2[sidx] = x1_ff[sidx];
        nxt_x1[sidx] = chv_ff[cur_ch];
        nxt_y2[sidx] = y1_ff[sidx];
        nxt_y1[sidx] = bq_y;
        nxt_sect = 4'(sect_ff + 4'h1);
        if (4'(sect_ff + 4'h1) == nsect_used)
          nxt_st = RBSM_DONE;
      end
      RBSM_DONE:
      begin
        for (int c = 0; c < 4; c++)
          nxt_out[c] = chv_ff[c];
        if (sum_sel_ff == RBSM_SUM_AVG)
        begin
          nxt_out[0] = avg_sum[32:1];
          nxt_out[1] = avg_sum[32:1];
        end
        else if (sum_sel_ff == RBSM_SUM_OFF)
        begin
          nxt_out[0] = mix_acc[0][62:31];
          nxt_out[1] = mix_acc[1][62:31];
        end
        nxt_out_valid = 1'b1;
        nxt_st = RBSM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_ff        <= RBSM_IDLE;
      sect_ff      <= 4'h0;
      out_valid_ff <= 1'b0;
      for (int c = 0; c < 4; c++)
      begin
        chv_ff[c] <= 32'h00000000;
        in_ff[c]  <= 32'h00000000;
        out_ff[c] <= 32'h00000000;
      end
      for (int s = 0; s < 12; s++)
      begin
        x1_ff[s] <= 32'h00000000;
        x2_ff[s] <= 32'h00000000;
        y1_ff[s] <= 32'h00000000;
        y2_ff[s] <= 32'h00000000;
      end
    end
    else
    begin
      st_ff        <= nxt_st;
      sect_ff      <= nxt_sect;
      out_valid_ff <= nxt_out_valid;
      for (int c = 0; c < 4; c++)
      begin
        chv_ff[c] <= nxt_chv[c];
        in_ff[c]  <= nxt_in[c];
        out_ff[c] <= nxt_out[c];
      end
      for (int s = 0; s < 12; s++)
      begin
        x1_ff[s] <= nxt_x1[s];
        x2_ff[s] <= nxt_x2[s];
        y1_ff[s] <= nxt_y1[s];
        y2_ff[s] <= nxt_y2[s];
      end
    end
  end

  assign out_valid_o = out_valid_ff;
  assign out_ch0_o   = out_ff[0];
  assign out_ch1_o   = out_ff[1];
  assign out_ch2_o   = out_ff[2];
  assign out_ch3_o   = out_ff[3];
endmodule : rbsm_top

// file: rbsm_monitor.sv
// Port assertions for the record filter block.
`timescale 1ns/1ps
module rbsm_monitor
(
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  // Register bus
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Streams
  input wire logic        in_valid_i,
  input wire logic        out_valid_o,
  input wire logic [31:0] out_ch0_o,
  input wire logic [31:0] out_ch1_o
);
  logic [1:0] alc_ff;
  logic [1:0] nxt_alc;
  logic [1:0] sum_ff;
  logic [1:0] nxt_sum;
  logic       busy_ff;
  logic       nxt_busy;
  logic       go;
  assign go = in_valid_i && !busy_ff;
  always_comb
  begin
    nxt_alc  = alc_ff;
    nxt_sum  = sum_ff;
    nxt_busy = (busy_ff || go) && !out_valid_o;
    if (pready_o && pwrite_i && !pslverr_o && paddr_i == 12'h000)
    begin
      nxt_alc = pwdata_i[6:5];
      nxt_sum = pwdata_i[3:2];
    end
  end
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      alc_ff  <= 2'h2;
      sum_ff  <= 2'h0;
      busy_ff <= 1'b0;
    end
    else
    begin
      alc_ff  <= nxt_alc;
      sum_ff  <= nxt_sum;
      busy_ff <= nxt_busy;
    end
  end
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  AST_RDY_WAIT: assert property (psel_i && penable_i && !pready_o
    |=> pready_o) else $error("late ready");
  AST_RDY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("long ready");
  AST_ERR_READ: assert property (pslverr_o && !pwrite_i
    |-> pready_o && prdata_o == 32'h0) else $error("bad error read");
  AST_COEF_MAP: assert property (pready_o && paddr_i[11:10] == 2'h1
    && paddr_i[8:5] != 4'h0 |-> !pslverr_o) else $error("coef refused");
  AST_LAT_ONE: assert property (go && alc_ff == 2'h1
    |-> ##7 out_valid_o) else $error("latency one");
  AST_LAT_TWO: assert property (go && alc_ff == 2'h2
    |-> ##11 out_valid_o) else $error("latency two");
  AST_LAT_THREE: assert property (go && alc_ff == 2'h3
    |-> ##15 out_valid_o) else $error("latency three");
  AST_SUM_EQ: assert property (out_valid_o && sum_ff == 2'h1
    |-> out_ch0_o == out_ch1_o) else $error("sum differs");
  AST_HOLD: assert property ($changed(out_ch0_o) |-> out_valid_o)
    else $error("output moved");
  cover property (go && alc_ff == 2'h3);
  cover property (out_valid_o && sum_ff == 2'h1);
  cover property (pslverr_o);
endmodule : rbsm_monitor
bind rbsm_top rbsm_monitor u_mon (.clock_i, .sys_rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .in_valid_i, .out_valid_o, .out_ch0_o, .out_ch1_o);

// file: rbsm_top_test.sv
// Self-checking bench for the record filter block.
`timescale 1ns/1ps
module rbsm_top_test;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               psel = 1'b0;
  logic               pen = 1'b0;
  logic               pwr = 1'b0;
  logic [11:0]        pa = 12'h0;
  logic [31:0]        pwd = 32'h0;
  logic               iv = 1'b0;
  logic [3:0][31:0]   xi = '0;
  wire [3:0][31:0]    yo;
  logic [31:0]        prd;
  logic [31:0]        rd;
  logic               rdy;
  logic               err;
  logic               er;
  logic               ov;
  logic signed [31:0] cf [12][5];
  logic signed [31:0] w [2][4];
  longint             hx [12][2];
  longint             hy [12][2];
  int                 alc;
  int                 sm;
  int                 fails = 0;
  int                 checks = 0;
  int                 cyc = 0;
  rbsm_top uut (.clock_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .in_valid_i(iv),
    .in_ch0_i(xi[0]), .in_ch1_i(xi[1]), .in_ch2_i(xi[2]),
    .in_ch3_i(xi[3]), .out_valid_o(ov), .out_ch0_o(yo[0]),
    .out_ch1_o(yo[1]), .out_ch2_o(yo[2]), .out_ch3_o(yo[3]));
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Each transfer ends with an idle edge so psel is never set twice.
  task automatic apb(input logic wt, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwr <= wt;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (rdy !== 1'b1);
    rd = prd;
    er = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wcoef(input int s);
    for (int k = 0; k < 5; k++)
      for (int b = 0; b < 4; b++)
        apb(1'b1, 12'(1024 + (s / 6) * 512 + (28 + 20 * (s % 6)
          + 4 * k + b) * 4 - 80), {24'h0, cf[s][k][31 - 8 * b -: 8]});
  endtask : wcoef
  function automatic longint sect(input int s, input longint x);
    longint a;
    a = cf[s][0] * x + 2 * cf[s][1] * hx[s][0] + cf[s][2] * hx[s][1]
      + 2 * cf[s][3] * hy[s][0] + cf[s][4] * hy[s][1];
    a = longint'(int'(a >>> 31));
    hx[s][1] = hx[s][0];
    hx[s][0] = x;
    hy[s][1] = hy[s][0];
    hy[s][0] = a;
    return a;
  endfunction : sect
  task automatic frame();
    longint b [4];
    longint e [4];
    for (int c = 0; c < 4; c++)
    begin
      b[c] = $signed($urandom) >>> 11;
      xi[c] <= 32'(b[c]);
      for (int s = c; s < 4 * alc; s += 4)
        b[c] = sect(s, b[c]);
      e[c] = b[c];
    end
    for (int m = 0; m < 2; m++)
      e[m] = sm ? (b[0] + b[1]) >>> 1 : (w[m][0] * b[0] + w[m][1] * b[1]
        + w[m][2] * b[2] + w[m][3] * b[3]) >>> 31;
    iv <= 1'b1;
    @(posedge clk);
    iv <= 1'b0;
    // A lost result is caught by the cycle ceiling, not by a local limit.
    do
      @(posedge clk);
    while (ov !== 1'b1);
    for (int c = 0; c < 4; c++)
      chk(yo[c], 32'(e[c]));
  endtask : frame
  // Reset clears history and mixer weights but keeps coefficients.
  task automatic run(input int a, input int s);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    hx = '{default: 0};
    hy = '{default: 0};
    alc = a;
    sm = s;
    apb(1'b1, 12'h000, 32'((a << 5) | (s << 2)));
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 4; c++)
      begin
        w[m][c] = $signed($urandom) >>> 3;
        apb(1'b1, 12'(256 + 4 * (m * 4 + c)), w[m][c]);
      end
    repeat (4) frame();
  endtask : run
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    rd = $urandom(32'hB9177DE5);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 12'h000, 32'h0);
    chk({30'h0, rd[6:5]}, 32'h2);
    chk({30'h0, rd[3:2]}, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h00000002);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    foreach (cf[s, k])
      cf[s][k] = $signed($urandom) >>> (k == 0 ? 1 : 3);
    for (int s = 0; s < 12; s++)
      wcoef(s);
    apb(1'b0, 12'h620, 32'h0);
    chk(rd, {24'h0, cf[6][0][31:24]});
    for (int a = 0; a < 4; a++)
      for (int s = 0; s < 2; s++)
        run(a, s);
    end_of_test();
  end
endmodule : rbsm_top_test
